//--- design/can_paged_defines.svh
`ifndef CAN_PAGED_DEFINES_SVH
`define CAN_PAGED_DEFINES_SVH

// word index inside the paged window (byte address is four times the index)
`define IDX_HIGH 6'h00
`define IDX_LOW 6'h01
`define IDX_DATA_FIRST 6'h02
`define IDX_DATA_FINAL 6'h09
`define IDX_TX_COUNT 6'h0e
`define IDX_RX_COUNT 6'h0f
`define IDX_STATUS 6'h0f
`define IDX_WINDOW_END 6'h10

// registers outside the paged window
`define IDX_PAGE_SELECT 6'h10
`define IDX_CONTROL 6'h11
`define IDX_FLAGS 6'h12

// page codes and the no-buffer code
`define PAGE_DIAG 3'h0
`define PAGE_FILTERS 3'h4
`define BUF_NONE 2'h3

// buffer status bit positions
`define BIT_ACC 3
`define BIT_READY 2
`define BIT_BUSY 1
`define BIT_HOLD 0

// fault confinement figures
`define TX_ERROR_STEP 9'h008
`define TX_STEP_LIMIT 9'h0f8
`define TX_BUS_OFF 9'h100
`define RX_ERROR_SMALL 8'h01
`define RX_ERROR_LARGE 8'h08
`define RX_LARGE_LIMIT 8'hf7
`define RX_COUNT_MAX 8'hff
`define PASSIVE_LIMIT 8'h7f
`define RX_RELOAD_ABOVE 8'h80
`define RX_RELOAD 8'h78

`endif

//--- design/can_paged_pkg.sv
package can_paged_pkg;

	typedef struct packed {
		logic [8:0] tx_error_count;
		logic [7:0] rx_error_count;
	} counters_type;

	typedef struct packed {
		logic [7:0] last_high;
		logic [7:0] last_low;
		logic [2:0][10:0] tag;
		logic [2:0] remote;
		logic [2:0][3:0] length;
		logic [2:0][7:0][7:0] data;
		logic [2:0] ready;
		logic [2:0] busy;
		logic [2:0] hold;
		logic [2:0] tx_pend;
		logic [2:0] acc;
		logic [2:0] rx_flag;
		logic [1:0][11:0] pattern;
		logic [1:0][11:0] care;
		logic [2:0] page;
		logic early_tx;
		logic [1:0] rx_target;
		logic filling_seen;
		logic ahb_wr;
		logic ahb_rd;
		logic [5:0] ahb_index;
		logic ready_out;
		logic [31:0] rdata;
		logic [10:0] tx_tag;
		logic tx_remote;
		logic [3:0] tx_length;
		logic [63:0] tx_data;
	} regs_type;

endpackage : can_paged_pkg

//--- design/accept_filter.sv
`timescale 1ns/100ps
module accept_filter (
	// filter setting
	input wire logic [11:0] pattern,
	input wire logic [11:0] care,
	// incoming frame
	input wire logic [10:0] tag,
	input wire logic remote,
	// result
	output logic match
);
	// bits 11..1 face the tag, bit 0 the remote flag
	assign match = ((({tag, remote} ^ pattern) & care) == 12'h000);
endmodule : accept_filter

//--- design/error_counters.sv
`timescale 1ns/100ps
`include "can_paged_defines.svh"
module error_counters (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// events from the protocol core
	input wire logic tx_error,
	input wire logic tx_success,
	input wire logic rx_error_small,
	input wire logic rx_error_large,
	input wire logic rx_success,
	// counters and confinement state
	output logic [8:0] tx_error_count,
	output logic [7:0] rx_error_count,
	output logic error_passive,
	output logic bus_off
);
	can_paged_pkg::counters_type s;
	can_paged_pkg::counters_type next_s;

	always_comb begin
		next_s = s;
		// once bus-off the counter freezes; recovery belongs to the protocol core
		if (s.tx_error_count < `TX_BUS_OFF) begin
			if (tx_error) begin
				next_s.tx_error_count = (s.tx_error_count >= `TX_STEP_LIMIT) ? `TX_BUS_OFF : s.tx_error_count + `TX_ERROR_STEP;
			end else if (tx_success && s.tx_error_count != 9'h000) begin
				next_s.tx_error_count = s.tx_error_count - 9'h001;
			end
		end
		if (rx_error_large) begin
			next_s.rx_error_count = (s.rx_error_count > `RX_LARGE_LIMIT) ? `RX_COUNT_MAX : s.rx_error_count + `RX_ERROR_LARGE;
		end else if (rx_error_small) begin
			next_s.rx_error_count = (s.rx_error_count == `RX_COUNT_MAX) ? s.rx_error_count : s.rx_error_count + `RX_ERROR_SMALL;
		end else if (rx_success) begin
			if (s.rx_error_count > `RX_RELOAD_ABOVE) begin
				next_s.rx_error_count = `RX_RELOAD;
			end else if (s.rx_error_count != 8'h00) begin
				next_s.rx_error_count = s.rx_error_count - 8'h01;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign tx_error_count = s.tx_error_count;
	assign rx_error_count = s.rx_error_count;
	assign bus_off = (s.tx_error_count >= `TX_BUS_OFF);
	assign error_passive = !bus_off
		&& (s.tx_error_count > {1'b0, `PASSIVE_LIMIT} || s.rx_error_count > `PASSIVE_LIMIT);
endmodule : error_counters

//--- design/can_paged_buffers_filters.sv
`timescale 1ns/100ps
`include "can_paged_defines.svh"
module can_paged_buffers_filters (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	// last frame seen on the bus
	input wire logic frame_seen,
	input wire logic [10:0] frame_tag,
	input wire logic frame_remote,
	input wire logic [3:0] frame_length,
	// reception from the protocol core
	input wire logic rx_filling,
	input wire logic rx_done,
	input wire logic [10:0] rx_tag,
	input wire logic rx_remote,
	input wire logic [3:0] rx_length,
	input wire logic [63:0] rx_data,
	input wire logic rx_error_small,
	input wire logic rx_error_large,
	// transmission to the protocol core
	input wire logic [1:0] tx_select,
	input wire logic tx_emptying,
	input wire logic tx_done,
	input wire logic tx_cancel,
	input wire logic tx_error,
	output logic [2:0] tx_request,
	output logic [10:0] tx_tag,
	output logic tx_remote,
	output logic [3:0] tx_length,
	output logic [63:0] tx_data,
	// confinement state
	output logic error_passive,
	output logic bus_off
);
	can_paged_pkg::regs_type s;
	can_paged_pkg::regs_type next_s;
	logic [8:0] tx_error_count;
	logic [7:0] rx_error_count;
	logic [1:0] match;
	logic [1:0] wbuf;
	logic [7:0] wd;

	////////////////////////////////////////////////////////////////////////////
	// helpers

	function automatic logic [1:0] buf_of(input logic [2:0] page);
		buf_of = (page == 3'h1 || page == 3'h2 || page == 3'h3) ? 2'(page - 3'h1) : `BUF_NONE;
	endfunction : buf_of

	function automatic logic [1:0] free_buf(input logic [2:0] hold, input logic [2:0] ready);
		free_buf = `BUF_NONE;
		for (int i = 2; i >= 0; i--) begin
			if (!hold[i] && !ready[i]) begin
				free_buf = 2'(i);
			end
		end
	endfunction : free_buf

	function automatic logic [7:0] read_byte(input can_paged_pkg::regs_type r,
		input logic [8:0] t, input logic [7:0] q);
		logic [1:0] b;
		logic [5:0] x;
		b = buf_of(r.page);
		x = r.ahb_index;
		read_byte = 8'h00;
		if (x == `IDX_PAGE_SELECT) begin
			read_byte = {5'h00, r.page};
		end else if (x == `IDX_CONTROL) begin
			read_byte = {7'h00, r.early_tx};
		end else if (x == `IDX_FLAGS) begin
			read_byte = {5'h00, r.rx_flag};
		end else if (x < `IDX_WINDOW_END) begin
			// pages 5 to 7 and reserved slots read as zero
			if (r.page == `PAGE_DIAG) begin
				if (x == `IDX_HIGH) read_byte = r.last_high;
				if (x == `IDX_LOW) read_byte = r.last_low;
				if (x == `IDX_TX_COUNT) read_byte = t[7:0];
				if (x == `IDX_RX_COUNT) read_byte = q;
			end else if (b != `BUF_NONE) begin
				if (x == `IDX_HIGH) read_byte = r.tag[b][10:3];
				if (x == `IDX_LOW) read_byte = {r.tag[b][2:0], r.remote[b], r.length[b]};
				if (x >= `IDX_DATA_FIRST && x <= `IDX_DATA_FINAL) begin
					read_byte = r.data[b][3'(x - `IDX_DATA_FIRST)];
				end
				if (x == `IDX_STATUS) begin
					read_byte = {4'h0, r.acc[b], r.ready[b], r.busy[b], r.hold[b]};
				end
			end else if (r.page == `PAGE_FILTERS && x < 6'h08) begin
				case (x[1:0])
					2'h0: read_byte = r.pattern[x[2]][11:4];
					2'h1: read_byte = {r.pattern[x[2]][3:0], 4'h0};
					2'h2: read_byte = r.care[x[2]][11:4];
					default: read_byte = {r.care[x[2]][3:0], 4'h0};
				endcase
			end
		end
	endfunction : read_byte

	////////////////////////////////////////////////////////////////////////////
	// fault confinement and acceptance

	error_counters counters (
		.hclk(hclk),
		.hresetn(hresetn),
		.tx_error(tx_error),
		.tx_success(tx_done),
		.rx_error_small(rx_error_small),
		.rx_error_large(rx_error_large),
		.rx_success(rx_done),
		.tx_error_count(tx_error_count),
		.rx_error_count(rx_error_count),
		.error_passive(error_passive),
		.bus_off(bus_off)
	);

	for (genvar f = 0; f < 2; f++) begin : g_filter
		accept_filter filt (
			.pattern(s.pattern[f]),
			.care(s.care[f]),
			.tag(rx_tag),
			.remote(rx_remote),
			.match(match[f])
		);
	end

	assign wbuf = buf_of(s.page);
	assign wd = hwdata[7:0];

	////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		next_s = s;
		next_s.ready_out = 1'b1;
		next_s.ahb_wr = 1'b0;
		next_s.ahb_rd = 1'b0;
		// address phase; reads take one wait state so data comes from a flop
		if (hsel && hready && htrans[1]) begin
			next_s.ahb_wr = hwrite;
			next_s.ahb_rd = !hwrite;
			next_s.ahb_index = haddr[7:2];
			next_s.ready_out = hwrite;
		end
		if (s.ahb_rd) begin
			next_s.rdata = {24'h000000, read_byte(s, tx_error_count, rx_error_count)};
		end

		// data phase of a write
		if (s.ahb_wr) begin
			if (s.ahb_index == `IDX_PAGE_SELECT) begin
				next_s.page = wd[2:0];
			end else if (s.ahb_index == `IDX_CONTROL) begin
				next_s.early_tx = wd[0];
			end else if (s.ahb_index == `IDX_FLAGS) begin
				next_s.rx_flag = s.rx_flag & wd[2:0];
			end else if (s.ahb_index < `IDX_WINDOW_END && s.page == `PAGE_DIAG) begin
				if (s.ahb_index == `IDX_HIGH) next_s.last_high = wd;
				if (s.ahb_index == `IDX_LOW) next_s.last_low = wd;
			end else if (s.ahb_index < `IDX_WINDOW_END && wbuf != `BUF_NONE) begin
				if (s.ahb_index == `IDX_HIGH) next_s.tag[wbuf][10:3] = wd;
				if (s.ahb_index == `IDX_LOW) begin
					{next_s.tag[wbuf][2:0], next_s.remote[wbuf], next_s.length[wbuf]} = wd;
				end
				if (s.ahb_index >= `IDX_DATA_FIRST && s.ahb_index <= `IDX_DATA_FINAL) begin
					next_s.data[wbuf][3'(s.ahb_index - `IDX_DATA_FIRST)] = wd;
				end
				if (s.ahb_index == `IDX_DATA_FINAL) begin
					next_s.tx_pend[wbuf] = 1'b1;
				end
				if (s.ahb_index == `IDX_STATUS) begin
					// releasing a received frame also drops its flag
					if (!s.hold[wbuf] && !wd[`BIT_READY]) begin
						next_s.ready[wbuf] = 1'b0;
						next_s.rx_flag[wbuf] = 1'b0;
					end
					// changing hold mid-access would corrupt the frame
					if (!s.busy[wbuf]) begin
						next_s.hold[wbuf] = wd[`BIT_HOLD];
						if (s.hold[wbuf] && !wd[`BIT_HOLD]) begin
							next_s.tx_pend[wbuf] = 1'b0;
							next_s.ready[wbuf] = 1'b0;
						end
					end
				end
			end else if (s.ahb_index < 6'h08 && s.page == `PAGE_FILTERS) begin
				case (s.ahb_index[1:0])
					2'h0: next_s.pattern[s.ahb_index[2]][11:4] = wd;
					2'h1: next_s.pattern[s.ahb_index[2]][3:0] = wd[7:4];
					2'h2: next_s.care[s.ahb_index[2]][11:4] = wd;
					default: next_s.care[s.ahb_index[2]][3:0] = wd[7:4];
				endcase
			end
		end

		// last frame capture
		if (frame_seen) begin
			{next_s.last_high, next_s.last_low} =
				{frame_tag, frame_remote, frame_length};
		end

		// target chosen when the frame starts; held buffers are never picked
		next_s.filling_seen = rx_filling;
		if (rx_filling && !s.filling_seen) begin
			next_s.rx_target = free_buf(s.hold, s.ready);
		end
		if (rx_done && s.rx_target != `BUF_NONE && !s.hold[s.rx_target]
			&& (match[0] || match[1])) begin
			next_s.tag[s.rx_target] = rx_tag;
			next_s.remote[s.rx_target] = rx_remote;
			next_s.length[s.rx_target] = rx_length;
			next_s.data[s.rx_target] = rx_data;
			next_s.acc[s.rx_target] = !match[0];
			next_s.ready[s.rx_target] = 1'b1;
			next_s.rx_flag[s.rx_target] = 1'b1;
			next_s.rx_target = `BUF_NONE;
		end

		// transmit completion or abandonment
		if ((tx_done || tx_cancel) && tx_select != `BUF_NONE) begin
			next_s.tx_pend[tx_select] = 1'b0;
			if (s.hold[tx_select]) begin
				next_s.ready[tx_select] = 1'b0;
			end
			if (tx_done && s.early_tx) begin
				next_s.hold[tx_select] = 1'b0;
			end
		end

		for (int i = 0; i < 3; i++) begin
			if (next_s.tx_pend[i] && next_s.hold[i]) begin
				next_s.ready[i] = 1'b1;
			end
			next_s.busy[i] = (rx_filling && s.rx_target == 2'(i) && !s.hold[i])
				|| (tx_emptying && tx_select == 2'(i) && s.hold[i]);
			if ((s.ready[i] && !next_s.ready[i]) || (s.rx_flag[i] && !next_s.rx_flag[i])) begin
				next_s.acc[i] = 1'b0;
			end
		end

		// outgoing frame for the buffer the core is serving
		if (tx_select != `BUF_NONE) begin
			next_s.tx_tag = s.tag[tx_select];
			next_s.tx_remote = s.remote[tx_select];
			next_s.tx_length = s.length[tx_select];
			next_s.tx_data = s.data[tx_select];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s <= '0;
			s.ready_out <= 1'b1;
			s.rx_target <= `BUF_NONE;
		end else begin
			s <= next_s;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs

	assign hreadyout = s.ready_out;
	assign hrdata = s.rdata;
	assign hresp = 1'b0;
	assign tx_request = s.ready & s.hold;
	assign tx_tag = s.tx_tag;
	assign tx_remote = s.tx_remote;
	assign tx_length = s.tx_length;
	assign tx_data = s.tx_data;

	////////////////////////////////////////////////////////////////////////////
	// checks

	property p_last_frame;
		@(posedge hclk) disable iff (!hresetn)
		frame_seen |=> {s.last_high, s.last_low}
			== {$past(frame_tag), $past(frame_remote), $past(frame_length)};
	endproperty
	a_last_frame: assert property (p_last_frame) else $error("last frame not captured");

	property p_tx_step;
		@(posedge hclk) disable iff (!hresetn)
		tx_error && tx_error_count < 9'h0f8 |=> tx_error_count == $past(tx_error_count) + 9'h008;
	endproperty
	a_tx_step: assert property (p_tx_step) else $error("transmit count not raised by 8");

	property p_tx_dec;
		@(posedge hclk) disable iff (!hresetn)
		tx_done && !tx_error && tx_error_count != 9'h000 && !bus_off |=> tx_error_count == $past(tx_error_count) - 9'h001;
	endproperty
	a_tx_dec: assert property (p_tx_dec) else $error("transmit count not lowered");

	property p_passive;
		@(posedge hclk) disable iff (!hresetn)
		error_passive == (!bus_off && (tx_error_count > 9'd127 || rx_error_count > 8'd127));
	endproperty
	a_passive: assert property (p_passive) else $error("passive state wrong");

	property p_bus_off;
		@(posedge hclk) disable iff (!hresetn)
		bus_off |=> bus_off && tx_error_count == 9'd256;
	endproperty
	a_bus_off: assert property (p_bus_off) else $error("bus-off left or wrong count");

	property p_rx_reload;
		@(posedge hclk) disable iff (!hresetn)
		rx_done && !rx_error_small && !rx_error_large && rx_error_count > 8'd128 |=> rx_error_count == 8'd120;
	endproperty
	a_rx_reload: assert property (p_rx_reload) else $error("receive count not reloaded");

	property p_held_keeps;
		@(posedge hclk) disable iff (!hresetn)
		s.hold[0] && !s.ahb_wr |=> $stable(s.tag[0]) && $stable(s.data[0]);
	endproperty
	a_held_keeps: assert property (p_held_keeps) else $error("held buffer overwritten");

	property p_hold_busy;
		@(posedge hclk) disable iff (!hresetn)
		s.busy[1] && !(tx_done && s.early_tx) |=> s.hold[1] == $past(s.hold[1]);
	endproperty
	a_hold_busy: assert property (p_hold_busy) else $error("hold changed while busy");

	property p_acc_clear;
		@(posedge hclk) disable iff (!hresetn)
		$fell(s.ready[1]) |-> !s.acc[1];
	endproperty
	a_acc_clear: assert property (p_acc_clear) else $error("filter index kept");

	property p_request;
		@(posedge hclk) disable iff (!hresetn)
		tx_request[0] |-> s.hold[0] && s.ready[0];
	endproperty
	a_request: assert property (p_request) else $error("request without held ready");

	c_store: cover property (@(posedge hclk) disable iff (!hresetn) $rose(s.ready[0]) && !s.hold[0]);
	c_second: cover property (@(posedge hclk) disable iff (!hresetn) $rose(s.acc[1]));
	c_tx: cover property (@(posedge hclk) disable iff (!hresetn) tx_done && s.hold[2]);
	c_off: cover property (@(posedge hclk) disable iff (!hresetn) $rose(bus_off));
endmodule : can_paged_buffers_filters

//--- bench/can_core_model.sv
`timescale 1ns/100ps
module can_core_model (
	// clock
	input wire logic hclk,
	// frames seen and received
	output logic frame_seen,
	output logic [10:0] frame_tag,
	output logic frame_remote,
	output logic [3:0] frame_length,
	output logic rx_filling,
	output logic rx_done,
	output logic [10:0] rx_tag,
	output logic rx_remote,
	output logic [3:0] rx_length,
	output logic [63:0] rx_data,
	output logic rx_error_small,
	output logic rx_error_large,
	// transmission service
	output logic [1:0] tx_select,
	output logic tx_emptying,
	output logic tx_done,
	output logic tx_cancel,
	output logic tx_error
);
	logic [3:0] pulse;

	assign {rx_error_large, rx_error_small, tx_done, tx_error} = pulse;

	initial begin
		pulse = '0;
		{frame_seen, rx_filling, rx_done, tx_emptying, tx_cancel} = '0;
		{frame_tag, frame_remote, frame_length} = '0;
		{rx_tag, rx_remote, rx_length, rx_data} = '0;
		tx_select = 2'h3;
	end

	////////////////////////////////////////////////////////////////////////////////
	// one frame from another node; the length code never exceeds eight
	task automatic receive(input logic [10:0] t, input logic r, input logic [3:0] n);
		rx_filling <= 1'b1;
		repeat (3) @(posedge hclk);
		{frame_seen, rx_done} <= 2'h3;
		{frame_tag, rx_tag} <= {t, t};
		{frame_remote, rx_remote} <= {r, r};
		{frame_length, rx_length} <= {n, n};
		rx_data <= 64'h8877665544332211;
		@(posedge hclk);
		{frame_seen, rx_done, rx_filling} <= 3'h0;
		// frame fields are stale now: invert rx_data and rx_tag so nothing leans on old values
		rx_data <= ~rx_data;
		rx_tag <= ~rx_tag;
		@(posedge hclk);
	endtask : receive

	// k: 0 tx error, 1 tx success, 2 small rx error, 3 large rx error
	task automatic evt(input int k, input int n);
		repeat (n) begin
			pulse[k] <= 1'b1;
			@(posedge hclk);
			pulse[k] <= 1'b0;
			@(posedge hclk);
		end
	endtask : evt

	task automatic serve(input logic [1:0] b);
		tx_select <= b;
		tx_emptying <= 1'b1;
		repeat (3) @(posedge hclk);
	endtask : serve

	task automatic finish_tx(input logic ok);
		if (ok)
			pulse[1] <= 1'b1;
		else
			tx_cancel <= 1'b1;
		@(posedge hclk);
		{pulse[1], tx_cancel, tx_emptying} <= 3'h0;
		tx_select <= 2'h3;
		@(posedge hclk);
	endtask : finish_tx
endmodule : can_core_model

//--- bench/can_paged_buffers_filters_test.sv
`timescale 1ns/100ps
module can_paged_buffers_filters_test;
	logic hclk = 1'b0;
	logic hresetn;
	logic hsel;
	logic [31:0] haddr;
	logic [1:0] htrans;
	logic hwrite;
	logic [2:0] hsize;
	logic [31:0] hwdata;
	logic hready;
	logic hreadyout;
	logic hresp;
	logic [31:0] hrdata;
	logic frame_seen, frame_remote, rx_filling, rx_done, rx_remote;
	logic rx_error_small, rx_error_large, tx_emptying, tx_done, tx_cancel, tx_error;
	logic tx_remote, error_passive, bus_off;
	logic [10:0] frame_tag, rx_tag, tx_tag;
	logic [3:0] frame_length, rx_length, tx_length;
	logic [63:0] rx_data, tx_data;
	logic [1:0] tx_select;
	logic [2:0] tx_request;
	int n_mismatch = 0;
	int n_tests = 0;

	always #50 hclk = ~hclk;
	// single slave: its ready is the bus ready
	assign hready = hreadyout;

	can_paged_buffers_filters dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
		.hsize, .hwdata, .hready, .hreadyout, .hrdata, .hresp, .frame_seen, .frame_tag,
		.frame_remote, .frame_length, .rx_filling, .rx_done, .rx_tag, .rx_remote, .rx_length,
		.rx_data, .rx_error_small, .rx_error_large, .tx_select, .tx_emptying, .tx_done,
		.tx_cancel, .tx_error, .tx_request, .tx_tag, .tx_remote, .tx_length, .tx_data,
		.error_passive, .bus_off);

	can_core_model node (.hclk, .frame_seen, .frame_tag, .frame_remote, .frame_length,
		.rx_filling, .rx_done, .rx_tag, .rx_remote, .rx_length, .rx_data, .rx_error_small,
		.rx_error_large, .tx_select, .tx_emptying, .tx_done, .tx_cancel, .tx_error);

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// called at a rising edge; waits on hready with no assumed latency
	task automatic bus(input logic w, input logic [5:0] i, input logic [7:0] d,
		output logic [31:0] q);
		hsel <= 1'b1;
		haddr <= {24'h0, i, 2'h0};
		htrans <= 2'h2;
		hwrite <= w;
		hsize <= 3'h2;
		do @(posedge hclk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		do @(posedge hclk); while (hready !== 1'b1);
		q = hrdata;
	endtask : bus

	task automatic wr(input logic [5:0] i, input logic [7:0] d);
		logic [31:0] q;
		bus(1'b1, i, d, q);
	endtask : wr

	// upper bits must read zero as well
	task automatic rd(input logic [5:0] i, input logic [7:0] e);
		logic [31:0] q;
		bus(1'b0, i, 8'h00, q);
		chk({hresp, q}, {1'b0, 24'h0, e});
	endtask : rd

	task automatic do_reset();
		hresetn <= 1'b0;
		{hsel, hwrite, htrans} <= '0;
		hsize <= 3'h2;
		haddr <= '0;
		hwdata <= '0;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
	endtask : do_reset

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_rx_count();
		do_reset();
		rd(6'h0e, 8'h00);
		rd(6'h0f, 8'h00);
		node.evt(2, 1);
		node.evt(3, 15);
		node.evt(2, 7);
		rd(6'h0f, 8'h80);
		chk(error_passive, 1'b1);
		node.receive(11'h100, 1'b0, 4'h0);
		rd(6'h0f, 8'h7f);
		chk(error_passive, 1'b0);
		node.evt(3, 1);
		node.receive(11'h101, 1'b0, 4'h0);
		rd(6'h0f, 8'h78);
		$display("receive counter test done");
	endtask : t_rx_count

	task automatic t_tx_count();
		do_reset();
		node.evt(0, 16);
		rd(6'h0e, 8'h80);
		chk(error_passive, 1'b1);
		node.evt(1, 1);
		rd(6'h0e, 8'h7f);
		chk(error_passive, 1'b0);
		node.evt(0, 16);
		rd(6'h0e, 8'hff);
		chk(bus_off, 1'b0);
		node.evt(0, 1);
		rd(6'h0e, 8'h00);
		chk(bus_off, 1'b1);
		$display("transmit counter test done");
	endtask : t_tx_count

	// pair 0: tag 123h, remote ignored; pair 1: tag 456h remote frames only
	task automatic t_receive();
		logic [7:0] flt [8] = '{8'h24, 8'h6f, 8'hff, 8'he0, 8'h8a, 8'hd0, 8'hff, 8'hf0};
		do_reset();
		wr(6'h10, 8'h01);
		rd(6'h0f, 8'h00);
		wr(6'h10, 8'h04);
		for (int i = 0; i < 8; i++)
			wr(6'(i), flt[i]);
		rd(6'h01, 8'h60);
		node.receive(11'h123, 1'b1, 4'h2);
		node.receive(11'h456, 1'b0, 4'h1);
		node.receive(11'h456, 1'b1, 4'h0);
		wr(6'h10, 8'h00);
		rd(6'h00, 8'h8a);
		rd(6'h01, 8'hd0);
		rd(6'h12, 8'h03);
		wr(6'h10, 8'h01);
		rd(6'h0f, 8'h04);
		rd(6'h00, 8'h24);
		rd(6'h01, 8'h72);
		rd(6'h02, 8'h11);
		rd(6'h09, 8'h88);
		wr(6'h10, 8'h02);
		rd(6'h0f, 8'h0c);
		wr(6'h10, 8'h03);
		rd(6'h0f, 8'h00);
		// release the buffer that pair 1 filled, so the index must drop too
		wr(6'h10, 8'h02);
		wr(6'h0f, 8'h00);
		rd(6'h0f, 8'h00);
		rd(6'h12, 8'h01);
		wr(6'h12, 8'h00);
		rd(6'h12, 8'h00);
		wr(6'h10, 8'h05);
		rd(6'h00, 8'h00);
		wr(6'h3f, 8'hff);
		rd(6'h3f, 8'h00);
		$display("receive test done");
	endtask : t_receive

	task automatic t_transmit();
		do_reset();
		wr(6'h10, 8'h01);
		wr(6'h0f, 8'h01);
		node.receive(11'h7f0, 1'b0, 4'h1);
		rd(6'h0f, 8'h01);
		wr(6'h00, 8'hab);
		wr(6'h01, 8'ha8);
		for (int i = 2; i < 10; i++)
			wr(6'(i), 8'(i * 17));
		rd(6'h0f, 8'h05);
		chk(tx_request, 3'h1);
		node.serve(2'h0);
		chk({tx_tag, tx_remote, tx_length}, {11'h55d, 1'b0, 4'h8});
		chk(tx_data, 64'h9988776655443322);
		wr(6'h0f, 8'h00);
		rd(6'h0f, 8'h07);
		node.finish_tx(1'b1);
		rd(6'h0f, 8'h01);
		chk(tx_request, 3'h0);
		wr(6'h09, 8'h99);
		node.serve(2'h0);
		node.finish_tx(1'b0);
		rd(6'h0f, 8'h01);
		wr(6'h11, 8'h01);
		wr(6'h09, 8'h99);
		node.serve(2'h0);
		node.finish_tx(1'b1);
		rd(6'h0f, 8'h00);
		wr(6'h0f, 8'h01);
		wr(6'h09, 8'h99);
		rd(6'h0f, 8'h05);
		wr(6'h0f, 8'h00);
		rd(6'h0f, 8'h00);
		chk(tx_request, 3'h0);
		$display("transmit test done");
	endtask : t_transmit

	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : end_sim

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		t_receive();
		t_transmit();
		t_rx_count();
		t_tx_count();
		end_sim();
	end

	// the tests need a few hundred cycles; this leaves wide margin
	initial begin
		repeat (20000) @(posedge hclk);
		n_mismatch++;
		end_sim();
	end
endmodule : can_paged_buffers_filters_test
